// ===== verilog/fcsu_defs.vh
// Constants for the flash command and status host controller
// Operation
// - Write F0 anywhere resets to array
// - Program: AA/555, 55/2AA, A0/555, data
// - Chip erase: six cycles ending 10/555
// - Sector erase: sixth cycle 30 at sector
// - Identification: AA, 55, 90 then read codes
// - B0 anywhere suspends sector erase
// - Command cycles spaced under 50 us
// - Poll at program or erasing sector address
// - Reread after poll bit turns true
// - Recheck poll bit when fail bit set
`ifndef FCSU_DEFS_VH
`define FCSU_DEFS_VH
`define FCSU_ADDR_W      18
`define FCSU_UNLOCK1_A   18'h00555
`define FCSU_UNLOCK2_A   18'h002AA
`define FCSU_D_AA        8'hAA
`define FCSU_D_55        8'h55
`define FCSU_D_RESET     8'hF0
`define FCSU_D_PROG      8'hA0
`define FCSU_D_ERASE     8'h80
`define FCSU_D_CHIP      8'h10
`define FCSU_D_SECT      8'h30
`define FCSU_D_IDENT     8'h90
`define FCSU_D_SUSP      8'hB0
`define FCSU_D_RESUME    8'h30
`define FCSU_OP_READ     3'h0
`define FCSU_OP_RESET    3'h1
`define FCSU_OP_PROG     3'h2
`define FCSU_OP_CHIP     3'h3
`define FCSU_OP_SECT     3'h4
`define FCSU_OP_IDENT    3'h5
`define FCSU_OP_SUSP     3'h6
`define FCSU_OP_RESUME   3'h7
`define FCSU_BIT_POLL    7
`define FCSU_BIT_TOG1    6
`define FCSU_BIT_FAIL    5
`define FCSU_BIT_WIN     3
`define FCSU_BIT_TOG2    2
`define FCSU_STROBE_CYC  4'h3
`define FCSU_GAP_US      50
`define FCSU_CLK_MHZ     100
`define FCSU_GAP_CYC     (`FCSU_GAP_US * `FCSU_CLK_MHZ)
`endif

// ===== verilog/fcsu_host.v
// Host controller that issues command sequences and reads to the flash
`timescale 1ns/10ps
`include "fcsu_defs.vh"
module fcsu_host (
   input  wire        mclk_in,
   input  wire        arst_n_in,
   input  wire        req_valid_in,
   input  wire [2:0]  req_op_in,
   input  wire [17:0] req_addr_in,
   input  wire [7:0]  req_data_in,
   output wire        req_ready_out,
   output reg         rsp_valid_out,
   output reg  [7:0]  rsp_data_out,
   output reg  [17:0] flash_addr_out,
   output reg  [7:0]  flash_dq_out,
   output reg         flash_dq_oe_n_out,
   input  wire [7:0]  flash_dq_in,
   output reg         flash_cs_n_out,
   output reg         flash_we_n_out,
   output reg         flash_oe_n_out
);
   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_SETUP = 3'h1;
   localparam [2:0] ST_PULSE = 3'h2;
   localparam [2:0] ST_HOLD  = 3'h3;
   localparam [2:0] ST_RD    = 3'h4;
   localparam [2:0] ST_RDEND = 3'h5;

   reg [2:0]  st_q;
   reg [2:0]  op_q;
   reg [17:0] addr_q;
   reg [7:0]  data_q;
   reg [2:0]  cyc_q;
   reg [2:0]  ncyc_q;
   reg [3:0]  tmr_q;
   reg [17:0] cyc_addr;
   reg [7:0]  cyc_data;

   assign req_ready_out = (st_q == ST_IDLE);

   // Cycle table; whole sequence runs back to back, far below the gap limit
   always @* begin
      cyc_addr = `FCSU_UNLOCK1_A;
      cyc_data = `FCSU_D_AA;
      case (cyc_q)
         3'h0: begin
            cyc_addr = `FCSU_UNLOCK1_A;
            cyc_data = `FCSU_D_AA;
         end
         3'h1: begin
            cyc_addr = `FCSU_UNLOCK2_A;
            cyc_data = `FCSU_D_55;
         end
         3'h2: begin
            cyc_addr = `FCSU_UNLOCK1_A;
            case (op_q)
               `FCSU_OP_PROG:  cyc_data = `FCSU_D_PROG;
               `FCSU_OP_IDENT: cyc_data = `FCSU_D_IDENT;
               default:        cyc_data = `FCSU_D_ERASE;
            endcase
         end
         3'h3: begin
            if (op_q == `FCSU_OP_PROG) begin
               cyc_addr = addr_q;
               cyc_data = data_q;
            end else begin
               cyc_addr = `FCSU_UNLOCK1_A;
               cyc_data = `FCSU_D_AA;
            end
         end
         3'h4: begin
            cyc_addr = `FCSU_UNLOCK2_A;
            cyc_data = `FCSU_D_55;
         end
         3'h5: begin
            if (op_q == `FCSU_OP_SECT) begin
               cyc_addr = addr_q;
               cyc_data = `FCSU_D_SECT;
            end else begin
               cyc_addr = `FCSU_UNLOCK1_A;
               cyc_data = `FCSU_D_CHIP;
            end
         end
         default: begin
            cyc_addr = `FCSU_UNLOCK1_A;
            cyc_data = `FCSU_D_AA;
         end
      endcase
      // Single-cycle commands use the caller's address, any value works
      if (ncyc_q == 3'h1) begin
         cyc_addr = addr_q;
         cyc_data = data_q;
      end
   end

   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q              <= ST_IDLE;
         op_q              <= 3'h0;
         addr_q            <= 18'h00000;
         data_q            <= 8'h00;
         cyc_q             <= 3'h0;
         ncyc_q            <= 3'h0;
         tmr_q             <= 4'h0;
         rsp_valid_out     <= 1'b0;
         rsp_data_out      <= 8'h00;
         flash_addr_out    <= 18'h00000;
         flash_dq_out      <= 8'h00;
         flash_dq_oe_n_out <= 1'b1;
         flash_cs_n_out    <= 1'b1;
         flash_we_n_out    <= 1'b1;
         flash_oe_n_out    <= 1'b1;
      end else begin
         rsp_valid_out <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (req_valid_in) begin
                  op_q   <= req_op_in;
                  addr_q <= req_addr_in;
                  cyc_q  <= 3'h0;
                  tmr_q  <= 4'h0;
                  case (req_op_in)
                     `FCSU_OP_READ: begin
                        flash_addr_out <= req_addr_in;
                        st_q           <= ST_RD;
                     end
                     `FCSU_OP_RESET: begin
                        ncyc_q <= 3'h1;
                        data_q <= `FCSU_D_RESET;
                        st_q   <= ST_SETUP;
                     end
                     `FCSU_OP_SUSP: begin
                        ncyc_q <= 3'h1;
                        data_q <= `FCSU_D_SUSP;
                        st_q   <= ST_SETUP;
                     end
                     `FCSU_OP_RESUME: begin
                        ncyc_q <= 3'h1;
                        data_q <= `FCSU_D_RESUME;
                        st_q   <= ST_SETUP;
                     end
                     `FCSU_OP_PROG: begin
                        ncyc_q <= 3'h4;
                        data_q <= req_data_in;
                        st_q   <= ST_SETUP;
                     end
                     `FCSU_OP_IDENT: begin
                        ncyc_q <= 3'h3;
                        data_q <= req_data_in;
                        st_q   <= ST_SETUP;
                     end
                     default: begin
                        ncyc_q <= 3'h6;
                        data_q <= req_data_in;
                        st_q   <= ST_SETUP;
                     end
                  endcase
               end
            end
            ST_SETUP: begin
               // Address settles before both strobes are low
               flash_addr_out    <= cyc_addr;
               flash_dq_out      <= cyc_data;
               flash_dq_oe_n_out <= 1'b0;
               flash_cs_n_out    <= 1'b0;
               st_q              <= ST_PULSE;
            end
            ST_PULSE: begin
               flash_we_n_out <= 1'b0;
               tmr_q          <= tmr_q + 4'h1;
               if (tmr_q == `FCSU_STROBE_CYC) begin
                  tmr_q <= 4'h0;
                  st_q  <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               // Write strobe rises first so data is taken then
               flash_we_n_out <= 1'b1;
               if (flash_we_n_out) begin
                  flash_cs_n_out    <= 1'b1;
                  flash_dq_oe_n_out <= 1'b1;
                  if (cyc_q + 3'h1 == ncyc_q) begin
                     rsp_valid_out <= 1'b1;
                     st_q          <= ST_IDLE;
                  end else begin
                     cyc_q <= cyc_q + 3'h1;
                     st_q  <= ST_SETUP;
                  end
               end
            end
            ST_RD: begin
               // Each read is a separate strobe so the toggle bits advance
               // Polling, rereads and fail rechecks are caller reads
               flash_cs_n_out <= 1'b0;
               flash_oe_n_out <= 1'b0;
               tmr_q          <= tmr_q + 4'h1;
               if (tmr_q == `FCSU_STROBE_CYC) begin
                  rsp_data_out <= flash_dq_in;
                  st_q         <= ST_RDEND;
               end
            end
            ST_RDEND: begin
               flash_cs_n_out <= 1'b1;
               flash_oe_n_out <= 1'b1;
               rsp_valid_out  <= 1'b1;
               st_q           <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // fcsu_host

// ===== tb/fcsu_host_monitor.sv
// Pin protocol checker for the flash host controller
`timescale 1ns/10ps
module fcsu_host_monitor (
   input wire        mclk_in,
   input wire        arst_n_in,
   input wire        req_valid_in,
   input wire [2:0]  req_op_in,
   input wire        req_ready_out,
   input wire        rsp_valid_out,
   input wire [17:0] flash_addr_out,
   input wire [7:0]  flash_dq_out,
   input wire        flash_dq_oe_n_out,
   input wire        flash_cs_n_out,
   input wire        flash_we_n_out,
   input wire        flash_oe_n_out
);
   wire take = req_valid_in && req_ready_out;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   a_we_in_cs:
      assert property (!flash_we_n_out |-> !flash_cs_n_out) else $error("we low outside cs");
   a_write_drives_dq:
      assert property (!flash_we_n_out |-> flash_oe_n_out && !flash_dq_oe_n_out)
      else $error("write without dq drive");
   a_write_held:
      assert property (!flash_we_n_out && $past(!flash_we_n_out) |->
         $stable(flash_dq_out) && $stable(flash_addr_out)) else $error("write data moved");
   a_we_pulse_len:
      assert property ($fell(flash_we_n_out) |-> !flash_we_n_out [*4]) else $error("short we");
   a_read_strobe:
      assert property (!flash_oe_n_out |-> !flash_cs_n_out && flash_we_n_out && flash_dq_oe_n_out)
      else $error("bad read strobes");
   a_read_latency:
      assert property (take && req_op_in == 3'h0 |-> ##[6:7] rsp_valid_out)
      else $error("read answer late");
   a_busy_after_take:
      assert property (take |=> !req_ready_out) else $error("ready while busy");
   a_reset_single:
      assert property (take && req_op_in == 3'h1 |-> ##[2:12] rsp_valid_out)
      else $error("reset write late");
   a_program_len:
      assert property (take && req_op_in == 3'h2 |-> ##[25:33] rsp_valid_out)
      else $error("program length");
   a_chip_len:
      assert property (take && req_op_in == 3'h3 |-> ##[38:48] rsp_valid_out)
      else $error("chip erase length");
endmodule // fcsu_host_monitor
bind fcsu_host fcsu_host_monitor mon_u (.*);

// ===== tb/fcsu_flash_model.sv
// Behavioural flash device facing the host controller
`timescale 1ns/10ps
module fcsu_flash_model #(
   parameter [7:0] MAKER_CODE = 8'h11, // Arbitrary value
   parameter [7:0] PART_CODE  = 8'h22, // Arbitrary value
   parameter [7:0] CONT_CODE  = 8'h33, // Arbitrary value
   parameter       BUSY_READS = 3      // Busy lasts reads, not time, to keep runs short
) (
   input  wire [17:0] addr_in,
   input  wire [7:0]  dq_in,
   input  wire        cs_n_in,
   input  wire        we_n_in,
   input  wire        oe_n_in,
   output wire [7:0]  dq_out
);
   reg [7:0]  mem [0:255];
   reg [7:0]  r, pd;
   reg [17:0] la, pa;
   reg [2:0]  st;
   reg [4:0]  sa;
   reg        idm, ers, chip, susp, pgm, tg, tg2;
   integer    cnt, k;
   wire u1 = la[11:0] == 12'h555;
   wire u2 = la[11:0] == 12'h2AA;
   function [7:0] ix(input [17:0] a);
      ix = {a[17:13], a[2:0]};
   endfunction
   initial begin
      for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0] ^ 8'h5A;
      {st, idm, ers, chip, susp, pgm, tg, tg2, r} = 0;
   end
   always @(negedge we_n_in or negedge cs_n_in)
      if (!we_n_in && !cs_n_in) la = addr_in;
   always @(posedge we_n_in or posedge cs_n_in)
      if (we_n_in ^ cs_n_in) begin
         if (dq_in == 8'hF0) {st, idm} = 0;
         else if (ers && dq_in == 8'hB0) susp = 1;
         else if (susp && st == 0 && dq_in == 8'h30) susp = 0;
         else case (st)
            0, 4: st = (u1 && dq_in == 8'hAA) ? st + 1 : 0;
            1, 5: st = (u2 && dq_in == 8'h55) ? st + 1 : 0;
            2: begin
               st = !u1 ? 0 : dq_in == 8'hA0 ? 3 : dq_in == 8'h80 ? 4 : 0;
               idm = u1 && dq_in == 8'h90;
            end
            3: {st, pd, pa, pgm, cnt} = {3'h0, dq_in, la, 1'b1, BUSY_READS};
            default: begin
               st = 0;
               chip = u1 && dq_in == 8'h10;
               ers = chip || dq_in == 8'h30;
               sa = la[17:13];
               cnt = BUSY_READS;
            end
         endcase
      end
   always @(negedge oe_n_in or negedge cs_n_in)
      if (!oe_n_in && !cs_n_in) begin
         if (pgm) begin
            tg = ~tg;
            r = {~pd[7], tg, 6'h00};
            cnt = cnt - 1;
            if (cnt == 0) {pgm, mem[ix(pa)]} = {1'b0, mem[ix(pa)] & pd};
         end else if (idm)
            r = addr_in[1:0] == 0 ? MAKER_CODE : addr_in[1:0] == 1 ? PART_CODE :
                addr_in[1:0] == 3 ? CONT_CODE : 8'h00;
         else if (ers && (chip || addr_in[17:13] == sa)) begin
            if (!susp) {tg, cnt} = {~tg, cnt - 1};
            tg2 = ~tg2;
            r = {susp, tg, 2'b00, 1'b1, tg2, 2'b00};
            for (k = 0; k < 256; k = k + 1)
               if (cnt == 0 && (chip || k[7:3] == sa)) mem[k] = 8'hFF;
            if (cnt == 0) ers = 0;
         end else r = mem[ix(addr_in)];
      end
   // A released bus shows the inverse of its last value, never a stale match
   assign dq_out = (!oe_n_in && !cs_n_in) ? r : ~r;
endmodule // fcsu_flash_model

// ===== tb/fcsu_host_tb.sv
// Self-checking testbench for the flash host controller
`timescale 1ns/10ps
module fcsu_host_tb;
   reg         mclk_in = 0, arst_n_in = 0, req_valid_in = 0;
   reg  [2:0]  req_op_in = 0;
   reg  [17:0] req_addr_in = 0;
   reg  [7:0]  req_data_in = 0, v, p;
   wire        req_ready_out, rsp_valid_out, flash_dq_oe_n_out;
   wire        flash_cs_n_out, flash_we_n_out, flash_oe_n_out;
   wire [7:0]  rsp_data_out, flash_dq_out, flash_dq_in, dev_dq;
   wire [17:0] flash_addr_out;
   integer     fail_count = 0, num_checks = 0, i;
   assign flash_dq_in = flash_dq_oe_n_out ? dev_dq : flash_dq_out;
   initial forever #5 mclk_in = ~mclk_in;
   fcsu_host dut_u (.*);
   fcsu_flash_model mdl_u (.addr_in(flash_addr_out), .dq_in(flash_dq_in),
      .cs_n_in(flash_cs_n_out), .we_n_in(flash_we_n_out), .oe_n_in(flash_oe_n_out),
      .dq_out(dev_dq));
   task check(input [7:0] s, input [7:0] e);
      begin
         num_checks = num_checks + 1;
         if (s !== e) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task go(input [2:0] o, input [17:0] a, input [7:0] d);
      begin
         {req_valid_in, req_op_in, req_addr_in, req_data_in} <= {1'b1, o, a, d};
         i = 0;
         do begin @(posedge mclk_in); i = i + 1; end while (req_ready_out !== 1'b1 && i < 300);
         req_valid_in <= 0;
         do begin @(posedge mclk_in); i = i + 1; end while (rsp_valid_out !== 1'b1 && i < 300);
         // A hung handshake ends the run here rather than stalling it
         if (i >= 300) begin fail_count = fail_count + 1; print_verdict; end
         v = rsp_data_out;
      end
   endtask
   task rd(input [17:0] a);
      go(3'h0, a, 8'h00);
   endtask
   initial begin
      repeat (12) @(posedge mclk_in);
      arst_n_in <= 1;
      @(posedge mclk_in);
      rd(18'h00005); check(v, 8'h5F);
      $display("array read test done");
      go(3'h2, 18'h00003, 8'h12);
      rd(18'h00003); check(v[7], 1'b1);
      p = v;
      rd(18'h00003); check(v[6] ^ p[6], 1'b1);
      rd(18'h00003);
      rd(18'h00003); check(v, 8'h10);
      $display("program test done");
      go(3'h5, 18'h00000, 8'h00);
      rd(18'h00000); check(v, 8'h11);
      rd(18'h00001); check(v, 8'h22);
      rd(18'h00003); check(v, 8'h33);
      rd(18'h02002); check(v, 8'h00);
      go(3'h1, 18'h3F000, 8'h00);
      rd(18'h00005); check(v, 8'h5F);
      $display("identification test done");
      go(3'h4, 18'h02000, 8'h00);
      rd(18'h02001); check(v[7], 1'b0);
      check(v[5], 1'b0);
      check(v[3], 1'b1);
      go(3'h6, 18'h00000, 8'h00);
      rd(18'h02001); check(v[7], 1'b1);
      p = v;
      rd(18'h02001); check(v[6], p[6]);
      check(v[2] ^ p[2], 1'b1);
      rd(18'h00001); check(v, 8'h5B);
      go(3'h7, 18'h00000, 8'h00);
      rd(18'h02001);
      rd(18'h02001);
      rd(18'h02001); check(v, 8'hFF);
      $display("sector erase test done");
      go(3'h3, 18'h00000, 8'h00);
      rd(18'h00005); check(v[7], 1'b0);
      rd(18'h00005);
      rd(18'h00005);
      rd(18'h00005); check(v, 8'hFF);
      $display("chip erase test done");
      print_verdict;
   end
endmodule // fcsu_host_tb
